// *** inc/regfile_defines.vh ***
// Operation
// [RQ1] Sixteen 32-bit globals, four 80-bit extended registers
// [RQ2] Each call allocates sixteen fresh 32-bit locals
// [RQ3] Thirty-two registers addressable: globals plus current locals
// [RQ4] Cache holds four local frames on chip
// [RQ5] Full cache on call spills oldest frame
// [RQ6] Global fifteen is the memory frame pointer
// [RQ7] Calls and spills never touch globals or extended
// [RQ8] Load start sets destination scoreboard bit
// [RQ9] Load data write clears scoreboard bit
// [RQ10] Instructions referencing pending registers are held
// [RQ11] Unrelated instructions keep issuing during loads
// [RQ12] Three loads outstanding; a fourth waits
// [RQ13] Any register serves float; 80-bit for extended
// [RQ14] Return to spilled frame restores it first
`ifndef REGFILE_DEFINES_VH
`define REGFILE_DEFINES_VH
`define NUM_GLOBALS        16
`define NUM_LOCALS         16
`define NUM_FRAMES         4
`define NUM_EXT            4
`define MAX_LOADS          2'h3
`define FRAME_PTR_IDX      4'hF
`define FRAME_BYTES        32'h00000040
`define EXT_WIDTH          80
`define ST_IDLE            2'h0
`define ST_SPILL           2'h1
`define ST_FILL            2'h2
`endif

// *** src/scoreboard.v ***
`timescale 1ns/1ns
`include "regfile_defines.vh"
module scoreboard #(
  parameter NREG = 32
) (
  input  wire            clk_sys_in,
  input  wire            srst_in,
  input  wire            set_in,
  input  wire [4:0]      set_idx_in,
  input  wire            clr_in,
  input  wire [4:0]      clr_idx_in,
  output wire [NREG-1:0] busy_out,
  output wire [1:0]      count_out
);
  reg [NREG-1:0] busy_r;
  reg [1:0]      count_r;
  assign busy_out  = busy_r;
  assign count_out = count_r;
  // Set wins over clear on the same register
  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1) begin : g_bit
      always @(posedge clk_sys_in) begin
        if (srst_in) begin
          busy_r[g] <= 1'b0;
        end else if (set_in && set_idx_in == g) begin
          busy_r[g] <= 1'b1; // [RQ8]
        end else if (clr_in && clr_idx_in == g) begin
          busy_r[g] <= 1'b0; // [RQ9]
        end
      end
    end
  endgenerate
  // Outstanding load count
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      count_r <= 2'h0;
    end else if (set_in && !clr_in) begin
      count_r <= count_r + 2'h1;
    end else if (clr_in && !set_in) begin
      count_r <= count_r - 2'h1;
    end
  end
endmodule // scoreboard

// *** src/windowed_regfile.v ***
`timescale 1ns/1ns
`include "regfile_defines.vh"
module windowed_regfile (
  input  wire        clk_sys_in,
  input  wire        srst_in,
  // Issue port: up to two operand reads
  input  wire        issue_valid_in,
  input  wire [4:0]  rd_a_idx_in,
  input  wire [4:0]  rd_b_idx_in,
  input  wire [4:0]  dst_idx_in,
  input  wire        uses_dst_in,
  input  wire        is_load_in,
  input  wire        wr_en_in,
  input  wire [31:0] wr_data_in,
  input  wire        call_in,
  input  wire        ret_in,
  output reg         issue_ready_out,
  output reg  [31:0] rd_a_data_out,
  output reg  [31:0] rd_b_data_out,
  // Load return
  input  wire        ld_ret_valid_in,
  input  wire [4:0]  ld_ret_idx_in,
  input  wire [31:0] ld_ret_data_in,
  // Extended registers
  input  wire        ext_wr_en_in,
  input  wire [1:0]  ext_idx_in,
  input  wire [79:0] ext_wr_data_in,
  output reg  [79:0] ext_rd_data_out,
  // Procedure stack memory port
  output reg         mem_req_out,
  output reg         mem_we_out,
  output reg  [31:0] mem_addr_out,
  output reg  [31:0] mem_wdata_out,
  input  wire        mem_ack_in,
  input  wire [31:0] mem_rdata_in,
  output reg  [31:0] frame_pointer_out
);
  //----------------------------------------
  // Storage
  //----------------------------------------
  reg [31:0] glob_r [0:`NUM_GLOBALS-1];              // [RQ1]
  reg [79:0] ext_r  [0:`NUM_EXT-1];                  // [RQ1] [RQ13]
  reg [31:0] loc_r  [0:`NUM_FRAMES*`NUM_LOCALS-1];   // [RQ4]
  reg [1:0]  cur_r;      // Current cache slot
  reg [2:0]  used_r;     // Frames resident in cache
  reg [31:0] depth_r;    // Spilled frames in memory
  reg [1:0]  st_r;
  reg [3:0]  xfer_r;     // Word within spill or fill
  reg        req_pend_r;
  integer    i;
  wire [31:0] sb_busy;
  wire [1:0]  sb_count;
  //----------------------------------------
  // Hazard checks
  //----------------------------------------
  function [5:0] phys;   // Map 5-bit operand to cache word
    input [4:0] idx;
    input [1:0] slot;
    phys = {slot, idx[3:0]};
  endfunction
  wire hazard = sb_busy[rd_a_idx_in] | sb_busy[rd_b_idx_in] |
                (uses_dst_in & sb_busy[dst_idx_in]);             // [RQ10]
  wire load_full = is_load_in & (sb_count == `MAX_LOADS);        // [RQ12]
  wire idle = (st_r == `ST_IDLE);
  wire can_issue = issue_valid_in & idle & !hazard & !load_full; // [RQ11]
  wire [1:0] oldest = cur_r - (used_r[1:0] - 2'h1);
  wire [1:0] spill_slot = cur_r + 2'h1;                          // Oldest when full
  wire need_spill = can_issue & call_in & (used_r == 3'h4);      // [RQ5]
  wire need_fill = can_issue & ret_in & (used_r == 3'h1) & (depth_r != 32'h0); // [RQ14]
  wire sb_set = can_issue & is_load_in & !call_in & !ret_in;
  scoreboard #(.NREG(32)) i_scoreboard (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .set_in     (sb_set),
    .set_idx_in (dst_idx_in),
    .clr_in     (ld_ret_valid_in),
    .clr_idx_in (ld_ret_idx_in),
    .busy_out   (sb_busy),
    .count_out  (sb_count)
  );
  //----------------------------------------
  // Read ports and status
  //----------------------------------------
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      rd_a_data_out     <= 32'h00000000;
      rd_b_data_out     <= 32'h00000000;
      ext_rd_data_out   <= 80'h0;
      issue_ready_out   <= 1'b0;
      frame_pointer_out <= 32'h00000000;
    end else begin
      rd_a_data_out <= rd_a_idx_in[4] ? loc_r[phys(rd_a_idx_in, cur_r)] : glob_r[rd_a_idx_in[3:0]]; // [RQ3]
      rd_b_data_out <= rd_b_idx_in[4] ? loc_r[phys(rd_b_idx_in, cur_r)] : glob_r[rd_b_idx_in[3:0]];
      ext_rd_data_out   <= ext_r[ext_idx_in];
      issue_ready_out   <= idle & !hazard & !load_full;
      frame_pointer_out <= glob_r[`FRAME_PTR_IDX];                  // [RQ6]
    end
  end
  //----------------------------------------
  // Register writes
  //----------------------------------------
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      for (i = 0; i < `NUM_GLOBALS; i = i + 1) glob_r[i] <= 32'h00000000;
      for (i = 0; i < `NUM_EXT; i = i + 1) ext_r[i] <= 80'h0;
    end else begin
      if (can_issue && wr_en_in && !is_load_in && !dst_idx_in[4]) begin
        glob_r[dst_idx_in[3:0]] <= wr_data_in;
      end
      if (ld_ret_valid_in && !ld_ret_idx_in[4]) begin
        glob_r[ld_ret_idx_in[3:0]] <= ld_ret_data_in;              // [RQ9]
      end
      if (ext_wr_en_in) begin
        ext_r[ext_idx_in] <= ext_wr_data_in;                       // [RQ7]
      end
    end
  end
  // Local cache writes; new frames start cleared
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      for (i = 0; i < `NUM_FRAMES*`NUM_LOCALS; i = i + 1) loc_r[i] <= 32'h00000000;
    end else begin
      if (can_issue && call_in && !need_spill) begin
        for (i = 0; i < `NUM_LOCALS; i = i + 1) loc_r[{cur_r + 2'h1, i[3:0]}] <= 32'h00000000; // [RQ2]
      end
      if (can_issue && wr_en_in && !is_load_in && dst_idx_in[4] && !call_in && !ret_in) begin
        loc_r[phys(dst_idx_in, cur_r)] <= wr_data_in;
      end
      if (ld_ret_valid_in && ld_ret_idx_in[4]) begin
        loc_r[phys(ld_ret_idx_in, cur_r)] <= ld_ret_data_in;
      end
      if (st_r == `ST_FILL && mem_ack_in) begin
        loc_r[{oldest - 2'h1, xfer_r}] <= mem_rdata_in;            // [RQ14]
      end
      if (st_r == `ST_SPILL && mem_ack_in && xfer_r == 4'hF) begin
        for (i = 0; i < `NUM_LOCALS; i = i + 1) loc_r[{spill_slot, i[3:0]}] <= 32'h00000000; // [RQ2]
      end
    end
  end
  //----------------------------------------
  // Frame control and spill/fill sequencer
  //----------------------------------------
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      cur_r <= 2'h0; used_r <= 3'h1; depth_r <= 32'h0;
      st_r <= `ST_IDLE; xfer_r <= 4'h0; req_pend_r <= 1'b0;
      mem_req_out <= 1'b0; mem_we_out <= 1'b0;
      mem_addr_out <= 32'h0; mem_wdata_out <= 32'h0;
    end else begin
      case (st_r)
        `ST_IDLE: begin
          if (need_spill) begin
            st_r <= `ST_SPILL; xfer_r <= 4'h0;                    // [RQ5]
            mem_req_out <= 1'b1; mem_we_out <= 1'b1;
            mem_addr_out <= glob_r[`FRAME_PTR_IDX] + (depth_r * `FRAME_BYTES); // [RQ6]
            mem_wdata_out <= loc_r[{spill_slot, 4'h0}];
          end else if (need_fill) begin
            st_r <= `ST_FILL; xfer_r <= 4'h0;
            mem_req_out <= 1'b1; mem_we_out <= 1'b0;
            mem_addr_out <= glob_r[`FRAME_PTR_IDX] + ((depth_r - 32'h1) * `FRAME_BYTES);
          end else if (can_issue && call_in) begin
            cur_r <= cur_r + 2'h1; used_r <= used_r + 3'h1;       // [RQ4]
          end else if (can_issue && ret_in && used_r != 3'h1) begin
            cur_r <= cur_r - 2'h1; used_r <= used_r - 3'h1;
          end
        end
        `ST_SPILL: begin
          if (mem_ack_in) begin
            if (xfer_r == 4'hF) begin
              st_r <= `ST_IDLE; mem_req_out <= 1'b0;
              depth_r <= depth_r + 32'h1;
              cur_r <= cur_r + 2'h1;                               // Freed slot becomes current
            end else begin
              xfer_r <= xfer_r + 4'h1;
              mem_addr_out <= mem_addr_out + 32'h4;
              mem_wdata_out <= loc_r[{spill_slot, xfer_r + 4'h1}];
            end
          end
        end
        `ST_FILL: begin
          if (mem_ack_in) begin
            if (xfer_r == 4'hF) begin
              st_r <= `ST_IDLE; mem_req_out <= 1'b0;
              depth_r <= depth_r - 32'h1;
              cur_r <= cur_r - 2'h1;                               // Resume in restored frame
            end else begin
              xfer_r <= xfer_r + 4'h1;
              mem_addr_out <= mem_addr_out + 32'h4;
            end
          end
        end
        default: st_r <= `ST_IDLE;
      endcase
    end
  end
endmodule // windowed_regfile

// *** tb/regfile_sva.sv ***
`timescale 1ns/1ns
// Watches the stack port and the issue handshake of the register file
module regfile_sva (
  input wire        clk_sys_in, srst_in, issue_valid_in, call_in, ret_in, issue_ready_out,
  input wire        mem_req_out, mem_we_out, mem_ack_in,
  input wire [31:0] mem_addr_out, mem_wdata_out, frame_pointer_out
);
  logic [4:0] acks_r;
  // Words acknowledged in the current frame transfer
  always @(posedge clk_sys_in) begin
    if (srst_in || !mem_req_out) acks_r <= 5'h00;
    else if (mem_ack_in) acks_r <= acks_r + 5'h01;
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  a_req_holds: assert property (mem_req_out && !mem_ack_in |=> mem_req_out
    && $stable(mem_addr_out) && $stable(mem_wdata_out)) else $error("stack request moved before ack");
  a_word_step: assert property (mem_req_out && mem_ack_in ##1 mem_req_out
    |-> mem_addr_out == $past(mem_addr_out) + 32'h00000004) else $error("stack address not ascending");
  a_frame_len: assert property ($fell(mem_req_out) |-> acks_r == 5'h10)
    else $error("frame transfer not sixteen words");
  a_xfer_cause: assert property ($rose(mem_req_out) |-> $past(issue_valid_in && (call_in || ret_in)))
    else $error("stack transfer without call or return");
  a_spill_write: assert property ($rose(mem_req_out) && $past(call_in) |-> mem_we_out)
    else $error("spill is not a write");
  a_fill_read: assert property ($rose(mem_req_out) && $past(ret_in) |-> !mem_we_out)
    else $error("fill is not a read");
  a_frame_base: assert property ($rose(mem_req_out)
    |-> ((mem_addr_out - frame_pointer_out) & 32'h0000003F) == 32'h00000000) else $error("frame off pointer");
  a_busy_stalls: assert property ($past(mem_req_out) |-> !issue_ready_out)
    else $error("issue during stack transfer");
endmodule // regfile_sva

bind windowed_regfile regfile_sva i_regfile_sva (.*);

// *** tb/stack_mem_model.sv ***
`timescale 1ns/1ns
// Procedure stack memory, acks the first word and each later word alike, after slow_in plus one idle cycles of the request
module stack_mem_model (
  input  wire         clk_sys_in, srst_in, mem_req_in, mem_we_in,
  input  wire  [31:0] mem_addr_in, mem_wdata_in,
  input  wire  [1:0]  slow_in,
  output logic        mem_ack_out,
  output logic [31:0] mem_rdata_out
);
  logic [31:0] store_r [logic [31:0]];
  logic [1:0]  wait_r;
  // Known levels before the first edge
  initial begin
    mem_ack_out = 1'b0;
    mem_rdata_out = 32'h00000000;
  end
  // Data toggles when not answering so stale values never look valid
  always @(posedge clk_sys_in) begin
    mem_ack_out <= 1'b0;
    mem_rdata_out <= ~mem_rdata_out;
    if (srst_in || !mem_req_in || mem_ack_out) wait_r <= slow_in;
    else if (wait_r != 2'h0) wait_r <= wait_r - 2'h1;
    else begin
      mem_ack_out <= 1'b1;
      if (mem_we_in) store_r[mem_addr_in] = mem_wdata_in;
      mem_rdata_out <= store_r[mem_addr_in];
    end
  end
endmodule // stack_mem_model

// *** tb/windowed_regfile_bench.sv ***
`timescale 1ns/1ns
module windowed_regfile_bench;
  logic        clk_sys_in, srst_in, issue_valid_in, uses_dst_in, is_load_in, wr_en_in, call_in, ret_in;
  logic        ld_ret_valid_in, ext_wr_en_in, issue_ready_out, mem_req_out, mem_we_out, mem_ack_in, req_d;
  logic [4:0]  rd_a_idx_in, rd_b_idx_in, dst_idx_in, ld_ret_idx_in;
  logic [1:0]  ext_idx_in, slow;
  logic [31:0] wr_data_in, rd_a_data_out, rd_b_data_out, ld_ret_data_in, mem_addr_out, mem_wdata_out;
  logic [31:0] mem_rdata_in, frame_pointer_out, seed, gv [16], lv [5];
  logic [79:0] ext_wr_data_in, ext_rd_data_out, ev [4];
  int          n_fail, compares, spills, fills, waited, i;
  windowed_regfile i_windowed_regfile (.*);
  stack_mem_model i_stack_mem_model (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .mem_req_in(mem_req_out),
    .mem_we_in(mem_we_out), .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out), .slow_in(slow),
    .mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in));
  // System clock
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  // Count stack transfers as they start
  always @(posedge clk_sys_in) begin
    if (mem_req_out && !req_d) begin
      spills += mem_we_out;
      fills += !mem_we_out;
    end
    req_d <= mem_req_out;
  end
  function logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task chk(input string nm, input logic [79:0] e, g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Hold one instruction until taken or lim edges pass; fl is ud,ld,we,call,ret
  task iss(input logic [4:0] a, d, fl, input logic [31:0] wd, input int lim);
    {rd_a_idx_in, rd_b_idx_in, dst_idx_in, wr_data_in} = {a, a, d, wd};
    {uses_dst_in, is_load_in, wr_en_in, call_in, ret_in} = fl;
    issue_valid_in = 1'b1;
    waited = 0;
    do begin
      @(posedge clk_sys_in);
      #1;
      waited++;
    end while (!issue_ready_out && waited < lim);
    issue_valid_in = 1'b0;
  endtask
  task rd(input logic [4:0] a, input logic [31:0] e);
    iss(a, 5'h00, 5'h00, 32'h00000000, 300);
    chk("read data", e, rd_a_data_out);
    chk("read data b", e, rd_b_data_out);
  endtask
  task ldret(input logic [4:0] d, input logic [31:0] v);
    {ld_ret_valid_in, ld_ret_idx_in, ld_ret_data_in} = {1'b1, d, v};
    @(posedge clk_sys_in);
    #1;
    ld_ret_valid_in = 1'b0;
  endtask
  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    n_fail++;
    report_and_stop;
  end
  initial begin
    {seed, slow, srst_in} = {32'h00007CBD, 2'h0, 1'b1};
    {issue_valid_in, uses_dst_in, is_load_in, wr_en_in, call_in, ret_in, ld_ret_valid_in, ext_wr_en_in} = 8'h00;
    {rd_a_idx_in, rd_b_idx_in, dst_idx_in, ld_ret_idx_in, ext_idx_in} = 22'h000000;
    {wr_data_in, ld_ret_data_in, ext_wr_data_in} = 144'h0;
    repeat (20) @(posedge clk_sys_in);
    #1;
    srst_in = 1'b0;
    // Random globals with the frame base in global fifteen, random extended values
    for (i = 0; i < 16; i++) begin
      seed = xs(seed);
      gv[i] = (i == 15) ? 32'h00001000 : seed;
      iss(5'h00, i[4:0], 5'h14, gv[i], 300);
    end
    ext_wr_en_in = 1'b1;
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      ev[i] = {seed, xs(seed), seed[15:0]};
      {ext_idx_in, ext_wr_data_in} = {i[1:0], ev[i]};
      @(posedge clk_sys_in);
      #1;
    end
    ext_wr_en_in = 1'b0;
    chk("frame pointer", 32'h00001000, frame_pointer_out);
    // Four nested calls, the last spilling the oldest frame with slow acks
    slow = 2'h2;
    for (i = 0; i < 5; i++) begin
      if (i > 0) iss(5'h00, 5'h00, 5'h02, 32'h00000000, 300);
      if (i > 0) rd(5'h10, 32'h00000000);
      chk("spills", i == 4, spills);
      seed = xs(seed);
      lv[i] = seed;
      iss(5'h00, 5'h10, 5'h14, lv[i], 300);
    end
    for (i = 3; i >= 0; i--) begin
      iss(5'h00, 5'h00, 5'h01, 32'h00000000, 300);
      rd(5'h10, lv[i]);
      chk("fills", i == 0, fills);
    end
    for (i = 0; i < 16; i++) rd(i[4:0], gv[i]);
    for (i = 0; i < 4; i++) begin
      ext_idx_in = i[1:0];
      @(posedge clk_sys_in);
      #1;
      chk("extended", ev[i], ext_rd_data_out);
    end
    $display("test frames done");
    // Three loads pending; unrelated work flows, a fourth load and a reader wait
    slow = 2'h0;
    for (i = 1; i < 4; i++) iss(5'h00, i[4:0], 5'h18, 32'h00000000, 300);
    iss(5'h04, 5'h05, 5'h14, seed, 300);
    chk("unrelated wait", 1, waited);
    iss(5'h00, 5'h07, 5'h18, 32'h00000000, 2);
    chk("fourth load taken", 0, issue_ready_out);
    ldret(5'h02, ~seed);
    iss(5'h00, 5'h07, 5'h18, 32'h00000000, 300);
    chk("fourth load taken", 1, issue_ready_out);
    iss(5'h01, 5'h00, 5'h00, 32'h00000000, 2);
    chk("reader taken", 0, issue_ready_out);
    ldret(5'h01, seed);
    rd(5'h01, seed);
    rd(5'h02, ~seed);
    $display("test scoreboard done");
    report_and_stop;
  end
endmodule // windowed_regfile_bench
